// ==== ofp_pkg.sv ====
// constants, types and register map of the on-chip flash program/erase control
// ============================================================================
package ofp_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_MHZ       = 125;
  localparam int unsigned PROG_TIME_US  = 25000;
  localparam int unsigned ERASE_TIME_US = 10000;
  localparam int unsigned PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
  localparam int unsigned ERASE_CYCLES  = ERASE_TIME_US * CLK_MHZ;

  // ==========================================================================
  // array geometry
  localparam int unsigned FLASH_WORDS = 40960;
  localparam int unsigned PAGE_WORDS  = 32;
  localparam int unsigned OVL_WORDS   = 1024;
  localparam int unsigned NUM_BLOCKS  = 11;
  localparam int unsigned FADDR_W     = 18;
  localparam logic [FADDR_W-1:0] MID_BLK_BASE  = 18'h08000;
  localparam logic [FADDR_W-1:0] BIG_BLK_BASE  = 18'h18000;
  localparam logic [31:0]        ERASED_WORD   = 32'hFFFFFFFF;
  localparam int unsigned        AB_LOW_BITS   = 9;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_EBLK    = 8'h08;
  localparam logic [7:0] REG_OVL     = 8'h0C;
  localparam logic [7:0] REG_ADDR    = 8'h10;
  localparam logic [7:0] REG_DATA    = 8'h14;
  localparam logic [7:0] REG_RAMDATA = 8'h18;
  localparam logic [7:0] REG_BOOT    = 8'h1C;

  // control bit positions and reset values
  localparam int unsigned CB_HWE = 7;
  localparam int unsigned CB_SWE = 6;
  localparam int unsigned CB_ESU = 5;
  localparam int unsigned CB_PSU = 4;
  localparam int unsigned CB_EV  = 3;
  localparam int unsigned CB_PV  = 2;
  localparam int unsigned CB_E   = 1;
  localparam int unsigned CB_P   = 0;
  localparam logic [7:0] CTRL_RST_WE = 8'h80;
  localparam logic [7:0] CTRL_RST_WP = 8'h00;

  // status bit positions
  localparam int unsigned SB_DONE  = 0;
  localparam int unsigned SB_ERR   = 1;
  localparam int unsigned SB_BUSY  = 2;
  localparam int unsigned SB_MODE  = 4;
  localparam int unsigned SB_LOCK  = 8;

  typedef enum logic [1:0] {
    OFP_USER,
    OFP_BOOT,
    OFP_USER_PROG,
    OFP_PROGRAMMER
  } ofp_mode_t;

endpackage : ofp_pkg

// ==== ofp_serial_if.sv ====
// byte stream and bit-rate result passed from the serial receiver to the controller
interface ofp_serial_if;
  logic        byte_valid;
  logic [7:0]  byte_data;
  logic        locked;
  logic [19:0] bit_period;

  modport rx_side (output byte_valid, output byte_data, output locked, output bit_period);
  modport ctl_side (input byte_valid, input byte_data, input locked, input bit_period);
endinterface : ofp_serial_if

// ==== ofp_autobaud_rx.sv ====
// serial receiver that measures the host bit rate from a leading zero byte
module ofp_autobaud_rx
  import ofp_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // serial line
  input  wire logic rxd_i,
  // towards controller
  ofp_serial_if.rx_side ser
);

  typedef enum logic [2:0] {
    AB_WAIT_LOW, AB_MEASURE, AB_IDLE, AB_START, AB_DATA, AB_STOP
  } ofp_ab_state_t;

  ofp_ab_state_t state_q;
  logic [19:0]   cnt_q;
  logic [19:0]   period_q;
  logic [2:0]    bit_q;
  logic [7:0]    shift_q;
  logic          valid_q;
  logic          rx_q;

  assign ser.byte_valid = valid_q;
  assign ser.byte_data  = shift_q;
  assign ser.locked     = (state_q != AB_WAIT_LOW) && (state_q != AB_MEASURE);
  assign ser.bit_period = period_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) rx_q <= 1'b1;
    else       rx_q <= rxd_i;
  end

  // ==========================================================================
  // host sends H'00 first: start bit plus eight zeros is nine bit times low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q  <= AB_WAIT_LOW;
      cnt_q    <= 20'h00000;
      period_q <= 20'h00000;
      bit_q    <= 3'h0;
      shift_q  <= 8'h00;
      valid_q  <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      cnt_q   <= cnt_q + 20'h00001;
      case (state_q)
        AB_WAIT_LOW: begin
          cnt_q <= 20'h00000;
          if (!rx_q) state_q <= AB_MEASURE;
        end
        AB_MEASURE: begin
          if (rx_q) begin
            period_q <= cnt_q / 20'(AB_LOW_BITS);
            state_q  <= AB_IDLE;
          end
        end
        AB_IDLE: begin
          cnt_q <= 20'h00000;
          if (!rx_q) state_q <= AB_START;
        end
        AB_START: begin
          if (cnt_q >= (period_q >> 1)) begin
            cnt_q   <= 20'h00000;
            bit_q   <= 3'h0;
            state_q <= rx_q ? AB_IDLE : AB_DATA;
          end
        end
        AB_DATA: begin
          if (cnt_q >= period_q) begin
            cnt_q   <= 20'h00000;
            shift_q <= {rx_q, shift_q[7:1]};
            bit_q   <= bit_q + 3'h1;
            if (bit_q == 3'h7) state_q <= AB_STOP;
          end
        end
        default: begin
          if (cnt_q >= period_q) begin
            valid_q <= rx_q; // framing error drops the byte
            state_q <= AB_IDLE;
          end
        end
      endcase
    end
  end

endmodule : ofp_autobaud_rx

// ==== ofp_flash_ctrl.sv ====
// flash array, program/erase sequencer, ram overlay and wishbone register slave
//
// Our own choices: the Wishbone interface to the registers and the register addresses.
module ofp_flash_ctrl
  import ofp_pkg::*;
#(
  parameter int unsigned PROG_CNT  = ofp_pkg::PROG_CYCLES,
  parameter int unsigned ERASE_CNT = ofp_pkg::ERASE_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // mode straps and protect pin
  input  wire logic [3:0]  mode_pins_i,
  input  wire logic        hw_program_protect_pin_i,
  // serial channel
  input  wire logic        rxd_i,
  output logic             txd_o,
  // status
  output logic             op_busy_o
);

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_PROG, SEQ_ERASE, SEQ_WAIT} ofp_seq_t;

  // ==========================================================================
  // helpers
  function automatic ofp_mode_t decode_mode(input logic [3:0] md, input logic wp);
    if (md[3])      return OFP_PROGRAMMER;
    else if (md[1]) return OFP_BOOT;
    else if (!wp)   return OFP_USER_PROG;
    else            return OFP_USER;
  endfunction : decode_mode

  // block number of a byte address: 0-7 small, 8-9 mid, 10 big
  function automatic logic [3:0] block_of(input logic [FADDR_W-1:0] a);
    if (a < MID_BLK_BASE)      return {1'b0, a[14:12]};
    else if (a < BIG_BLK_BASE) return (a < 18'h10000) ? 4'h8 : 4'h9;
    else                       return 4'hA;
  endfunction : block_of

  function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : merge_sel

  // ==========================================================================
  // storage
  logic [31:0] flash_mem [FLASH_WORDS];
  logic [31:0] page_buf  [PAGE_WORDS];
  logic [31:0] ovl_ram   [OVL_WORDS];

  ofp_mode_t              mode_q;
  logic                   hwe;
  logic [6:0]             ctrl_q;
  logic [NUM_BLOCKS-1:0]  eblk_q;
  logic                   ovl_en_q;
  logic [2:0]             ovl_blk_q;
  logic [FADDR_W-1:0]     addr_q;
  logic                   done_q;
  logic                   err_q;
  logic [11:0]            load_ptr_q;
  logic                   ack_q;
  logic [31:0]            dat_q;
  ofp_seq_t               seq_q;
  logic [15:0]            idx_q;
  logic [31:0]            tmr_q;
  logic [31:0]            tmr_end_q;

  ofp_serial_if ser ();

  ofp_autobaud_rx u_rx (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .rxd_i (rxd_i),
    .ser   (ser.rx_side)
  );

  // ==========================================================================
  // decodes shared by bus and sequencer
  logic                req;
  logic                wr;
  logic [7:0]          reg_adr;
  logic                may_write;
  logic                mode_ok;
  logic                flash_in_range;
  logic                ovl_hit;
  logic                read_blocked;
  logic [15:0]         word_idx;
  logic [9:0]          ovl_idx;
  logic [NUM_BLOCKS-1:0] erase_mask;
  logic                p_start;
  logic                e_start;
  logic                p_refuse;
  logic                e_refuse;

  assign req            = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr             = req && wb_we_i;
  assign reg_adr        = {wb_adr_i[7:2], 2'b00};
  assign hwe            = !hw_program_protect_pin_i;
  assign may_write      = hwe && ctrl_q[CB_SWE];
  assign mode_ok        = (mode_q != OFP_USER);
  assign word_idx       = addr_q[FADDR_W-1:2];
  assign flash_in_range = word_idx < 16'(FLASH_WORDS);
  assign ovl_idx        = addr_q[11:2];
  assign ovl_hit        = ovl_en_q && (block_of(addr_q) == {1'b0, ovl_blk_q});
  // flash is hidden while writes are enabled unless a verify mode is set
  assign read_blocked   = ctrl_q[CB_SWE] && !ctrl_q[CB_EV] && !ctrl_q[CB_PV];
  assign erase_mask     = (mode_q == OFP_BOOT) ? {NUM_BLOCKS{1'b1}} : eblk_q;

  // program and erase start on a write that raises the bit from zero
  logic ctrl_wr;
  assign ctrl_wr  = wr && (reg_adr == REG_CTRL) && wb_sel_i[0];

  // byte-lane merges, kept whole so the registers can slice them
  logic [31:0] eblk_merged;
  logic [31:0] addr_merged;
  assign eblk_merged = merge_sel(32'(eblk_q), wb_dat_i, wb_sel_i);
  assign addr_merged = merge_sel(32'(addr_q), wb_dat_i, wb_sel_i);
  assign p_start  = ctrl_wr && wb_dat_i[CB_P] && !ctrl_q[CB_P] && may_write
                    && ctrl_q[CB_PSU] && mode_ok && flash_in_range && (seq_q == SEQ_IDLE);
  assign e_start  = ctrl_wr && wb_dat_i[CB_E] && !ctrl_q[CB_E] && may_write
                    && ctrl_q[CB_ESU] && mode_ok && (erase_mask != '0) && (seq_q == SEQ_IDLE);
  assign p_refuse = ctrl_wr && wb_dat_i[CB_P] && !ctrl_q[CB_P] && !p_start;
  assign e_refuse = ctrl_wr && wb_dat_i[CB_E] && !ctrl_q[CB_E] && !e_start;

  assign op_busy_o = (seq_q != SEQ_IDLE);
  assign txd_o     = 1'b1;
  assign wb_ack_o  = ack_q;
  assign wb_dat_o  = dat_q;

  // ==========================================================================
  // mode capture while reset is held
  always_ff @(posedge clk_i) begin
    if (rst_i) mode_q <= decode_mode(mode_pins_i, hw_program_protect_pin_i);
  end

  // ==========================================================================
  // control register
  always_ff @(posedge clk_i) begin
    if (rst_i || !hwe) begin
      ctrl_q <= 7'h00;
    end else if (ctrl_wr) begin
      ctrl_q[CB_SWE] <= wb_dat_i[CB_SWE];
      if (ctrl_q[CB_SWE]) begin
        ctrl_q[CB_ESU] <= wb_dat_i[CB_ESU];
        ctrl_q[CB_PSU] <= wb_dat_i[CB_PSU];
        ctrl_q[CB_EV]  <= wb_dat_i[CB_EV];
        ctrl_q[CB_PV]  <= wb_dat_i[CB_PV];
        if (ctrl_q[CB_ESU] || !wb_dat_i[CB_E]) ctrl_q[CB_E] <= wb_dat_i[CB_E] && mode_ok;
        if (ctrl_q[CB_PSU] || !wb_dat_i[CB_P]) ctrl_q[CB_P] <= wb_dat_i[CB_P] && mode_ok;
      end
    end
  end

  // ==========================================================================
  // erase block select, overlay control, address
  always_ff @(posedge clk_i) begin
    if (rst_i || !may_write) begin
      eblk_q <= '0;
    end else if (wr && (reg_adr == REG_EBLK)) begin
      eblk_q <= eblk_merged[NUM_BLOCKS-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovl_en_q  <= 1'b0;
      ovl_blk_q <= 3'h0;
    end else if (wr && (reg_adr == REG_OVL) && wb_sel_i[0]) begin
      ovl_en_q  <= wb_dat_i[3];
      ovl_blk_q <= wb_dat_i[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) addr_q <= '0;
    else if (wr && (reg_adr == REG_ADDR))
      addr_q <= addr_merged[FADDR_W-1:0];
  end

  // ==========================================================================
  // status flags: hardware set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      if (wr && (reg_adr == REG_STATUS) && wb_sel_i[0]) begin
        if (wb_dat_i[SB_DONE]) done_q <= 1'b0;
        if (wb_dat_i[SB_ERR])  err_q  <= 1'b0;
      end
      if ((seq_q == SEQ_WAIT) && (tmr_q >= tmr_end_q)) done_q <= 1'b1;
      if (p_refuse || e_refuse) err_q <= 1'b1;
    end
  end

  // ==========================================================================
  // page buffer: words gather here and reach the array only as a whole page
  always_ff @(posedge clk_i) begin
    if (wr && (reg_adr == REG_DATA) && !ovl_hit) begin
      page_buf[addr_q[6:2]] <= merge_sel(page_buf[addr_q[6:2]], wb_dat_i, wb_sel_i);
    end
  end

  // ==========================================================================
  // overlay ram, also the landing area of the boot loader
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_ptr_q <= 12'h000;
    end else if (ser.byte_valid && (mode_q == OFP_BOOT)) begin
      ovl_ram[load_ptr_q[11:2]][8*load_ptr_q[1:0] +: 8] <= ser.byte_data;
      load_ptr_q <= load_ptr_q + 12'h001;
    end else if (wr && (reg_adr == REG_DATA) && ovl_hit) begin
      ovl_ram[ovl_idx] <= merge_sel(ovl_ram[ovl_idx], wb_dat_i, wb_sel_i);
    end
  end

  // ==========================================================================
  // sequencer: programming only clears bits, erase sets whole blocks to ones
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_q     <= SEQ_IDLE;
      idx_q     <= 16'h0000;
      tmr_q     <= 32'h00000000;
      tmr_end_q <= 32'h00000000;
    end else begin
      tmr_q <= tmr_q + 32'h00000001;
      case (seq_q)
        SEQ_IDLE: begin
          idx_q <= 16'h0000;
          tmr_q <= 32'h00000001;
          if (p_start) begin
            seq_q     <= SEQ_PROG;
            tmr_end_q <= PROG_CNT;
          end else if (e_start) begin
            seq_q     <= SEQ_ERASE;
            tmr_end_q <= ERASE_CNT;
          end
        end
        SEQ_PROG: begin
          // page base ignores the low address bits, so a page never straddles
          flash_mem[{word_idx[15:5], idx_q[4:0]}] <=
            flash_mem[{word_idx[15:5], idx_q[4:0]}] & page_buf[idx_q[4:0]];
          idx_q <= idx_q + 16'h0001;
          if (idx_q == 16'(PAGE_WORDS - 1)) seq_q <= SEQ_WAIT;
        end
        SEQ_ERASE: begin
          if (erase_mask[block_of({idx_q, 2'b00})]) begin
            flash_mem[idx_q] <= ERASED_WORD;
          end
          idx_q <= idx_q + 16'h0001;
          if (idx_q == 16'(FLASH_WORDS - 1)) seq_q <= SEQ_WAIT;
        end
        default: begin
          if (tmr_q >= tmr_end_q) seq_q <= SEQ_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // wishbone answer: ack one cycle after the request, data registered with it
  always_ff @(posedge clk_i) begin
    if (rst_i) ack_q <= 1'b0;
    else       ack_q <= req;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h00000000;
    end else if (req && !wb_we_i) begin
      if (reg_adr == REG_CTRL) begin
        dat_q <= {24'h000000, (hwe ? CTRL_RST_WE[7] : CTRL_RST_WP[7]), ctrl_q};
      end else if (reg_adr == REG_STATUS) begin
        dat_q <= {23'h000000, ser.locked, 2'b00, mode_q, 1'b0,
                  op_busy_o, err_q, done_q};
      end else if (reg_adr == REG_EBLK) begin
        dat_q <= 32'(eblk_q);
      end else if (reg_adr == REG_OVL) begin
        dat_q <= {28'h0000000, ovl_en_q, ovl_blk_q};
      end else if (reg_adr == REG_ADDR) begin
        dat_q <= 32'(addr_q);
      end else if (reg_adr == REG_DATA) begin
        if (ovl_hit)
          dat_q <= ovl_ram[ovl_idx];
        else if (read_blocked || !flash_in_range)
          dat_q <= 32'h00000000;
        else
          dat_q <= flash_mem[word_idx];
      end else if (reg_adr == REG_RAMDATA) begin
        dat_q <= ovl_ram[ovl_idx];
      end else if (reg_adr == REG_BOOT) begin
        dat_q <= {ser.bit_period, load_ptr_q};
      end else begin
        dat_q <= 32'h00000000;
      end
    end
  end

endmodule : ofp_flash_ctrl

// ==== ofp_flash_ctrl_chk.sv ====
// port-level assertion checker for the flash program/erase controller
module ofp_flash_ctrl_chk
  import ofp_pkg::*;
#(
  parameter int unsigned PROG_CNT  = 64,
  parameter int unsigned ERASE_CNT = 64
) (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // pins and status
  input wire logic [3:0]  mode_pins_i,
  input wire logic        hw_program_protect_pin_i,
  input wire logic        rxd_i,
  input wire logic        txd_o,
  input wire logic        op_busy_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // helper: length of the current busy stretch
  // erase scans the whole array, so the bound is the larger of the two
  localparam int unsigned BUSY_MAX = ((ERASE_CNT > 40961) ? ERASE_CNT : 40961) + 8;
  int unsigned busy_cnt_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || !op_busy_o) busy_cnt_q <= 0;
    else busy_cnt_q <= busy_cnt_q + 1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================
  // bus handshake
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_hold: assert property ($changed(wb_dat_o) |-> $past(wb_cyc_i && wb_stb_i && !wb_we_i))
    else $error("read data changed without a read");
  a_txd_idle: assert property (txd_o)
    else $error("transmit line left idle level");

  // ==========================================
  // program and erase sequencing
  a_busy_cause: assert property ($rose(op_busy_o) |->
    wb_ack_o && wb_we_i && (wb_adr_i[7:2] == REG_CTRL[7:2]))
    else $error("busy rose without a register write");
  a_pin_blocks: assert property (hw_program_protect_pin_i && !op_busy_o |=> !op_busy_o)
    else $error("operation started while protect pin high");
  a_busy_min: assert property ($rose(op_busy_o) |-> op_busy_o [*8])
    else $error("operation ended too early");
  a_busy_bound: assert property (busy_cnt_q <= BUSY_MAX)
    else $error("operation busy too long");
endmodule : ofp_flash_ctrl_chk

bind ofp_flash_ctrl ofp_flash_ctrl_chk #(.PROG_CNT(PROG_CNT), .ERASE_CNT(ERASE_CNT)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mode_pins_i(mode_pins_i),
  .hw_program_protect_pin_i(hw_program_protect_pin_i), .rxd_i(rxd_i), .txd_o(txd_o),
  .op_busy_o(op_busy_o)
);

// ==== ofp_host_model.sv ====
// serial host that feeds the boot loader
module ofp_host_model (
  // clock
  input  wire logic clk_i,
  // serial line towards the device
  output logic      rxd_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial rxd_o = 1'b1;

  // ==========================================
  // 8N1, lsb first, line back to idle high after the stop bit
  task automatic send_byte(input logic [7:0] b, input int unsigned per);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      rxd_o <= fr[i];
      repeat (per - 1) @(posedge clk_i);
    end
  endtask : send_byte
endmodule : ofp_host_model

// ==== testbench.sv ====
// self-checking bench for the flash program/erase controller
module testbench
  import ofp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [3:0]  mode_pins_i;
  logic        hw_pin;
  logic        rxd;
  logic        txd_o;
  logic        op_busy_o;
  int          n_errors = 0;
  int          n_checks = 0;

  always #4 clk_i = ~clk_i;

  ofp_flash_ctrl #(.PROG_CNT(64), .ERASE_CNT(64)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mode_pins_i(mode_pins_i),
    .hw_program_protect_pin_i(hw_pin), .rxd_i(rxd), .txd_o(txd_o), .op_busy_o(op_busy_o)
  );
  ofp_host_model host (.clk_i(clk_i), .rxd_o(rxd));

  // ==========================================
  // common tasks
  task automatic complete_run();
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one classic cycle, entered just after a rising edge
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 16);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
    if (i >= 16) begin
      n_errors++;
      $display("[FAIL] bus ack expected 1 seen 0");
      complete_run();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask : rd

  task automatic do_reset(input logic [3:0] md, input logic pin);
    rst_i       <= 1'b1;
    mode_pins_i <= md;
    hw_pin      <= pin;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset

  // busy must show, then done within the bound; done is cleared after
  task automatic run_op();
    logic [31:0] q;
    int          i;
    rd(REG_STATUS, q);
    chk("busy", 32'h1, {31'h0, q[SB_BUSY]});
    for (i = 0; i < 20000; i++) begin
      rd(REG_STATUS, q);
      if (q[SB_DONE] === 1'b1) break;
    end
    if (i >= 20000) begin
      n_errors++;
      $display("[FAIL] done expected 1 seen 0");
      complete_run();
    end
    wr(REG_STATUS, 32'h1);
  endtask : run_op

  // ==========================================
  // scenarios
  task automatic t_protect();
    logic [31:0] q;
    do_reset(4'h8, 1'b1);
    rd(REG_STATUS, q);
    chk("mode programmer", {30'h0, OFP_PROGRAMMER}, {30'h0, q[SB_MODE+:2]});
    do_reset(4'h0, 1'b1);
    rd(REG_CTRL, q);
    chk("ctrl reset protected", {24'h0, CTRL_RST_WP}, q);
    rd(REG_STATUS, q);
    chk("mode user", {30'h0, OFP_USER}, {30'h0, q[SB_MODE+:2]});
    wr(REG_CTRL, 32'h41);
    rd(REG_CTRL, q);
    chk("ctrl protected", 32'h0, q);
    rd(REG_STATUS, q);
    chk("busy user", 32'h0, {31'h0, q[SB_BUSY]});
    chk("refused start", 32'h1, {31'h0, q[SB_ERR]});
    rd(8'h20, q);
    chk("unmapped", 32'h0, q);
  endtask : t_protect

  task automatic t_erase();
    logic [31:0] q;
    do_reset(4'h0, 1'b0);
    rd(REG_CTRL, q);
    chk("ctrl reset enabled", {24'h0, CTRL_RST_WE}, q);
    rd(REG_STATUS, q);
    chk("mode user prog", {30'h0, OFP_USER_PROG}, {30'h0, q[SB_MODE+:2]});
    wr(REG_CTRL, 32'h40);
    wr(REG_CTRL, 32'h60);
    wr(REG_EBLK, 32'h1);
    wr(REG_CTRL, 32'h62);
    run_op();
    wr(REG_CTRL, 32'h40);
    wr(REG_CTRL, 32'h48);
    wr(REG_ADDR, 32'h0);
    rd(REG_DATA, q);
    chk("erased first", ERASED_WORD, q);
    wr(REG_ADDR, 32'hFFC);
    rd(REG_DATA, q);
    chk("erased block end", ERASED_WORD, q);
  endtask : t_erase

  task automatic t_program();
    logic [31:0] q;
    wr(REG_CTRL, 32'h40);
    for (int w = 0; w < 32; w++) begin
      wr(REG_ADDR, 32'(w * 4));
      wr(REG_DATA, 32'h5A000000 + 32'(w));
    end
    wr(REG_CTRL, 32'h50);
    wr(REG_CTRL, 32'h51);
    run_op();
    wr(REG_CTRL, 32'h40);
    wr(REG_CTRL, 32'h44);
    for (int w = 0; w < 32; w++) begin
      wr(REG_ADDR, 32'(w * 4));
      rd(REG_DATA, q);
      chk("page word", 32'h5A000000 + 32'(w), q);
    end
    wr(REG_ADDR, 32'h80);
    rd(REG_DATA, q);
    chk("next page untouched", ERASED_WORD, q);
  endtask : t_program

  task automatic t_overlay();
    logic [31:0] q;
    wr(REG_CTRL, 32'h0);
    wr(REG_OVL, 32'h8);
    wr(REG_ADDR, 32'h0);
    wr(REG_DATA, 32'h12345678);
    rd(REG_DATA, q);
    chk("overlay read", 32'h12345678, q);
    wr(REG_OVL, 32'h0);
    rd(REG_DATA, q);
    chk("overlay released", 32'h5A000000, q);
  endtask : t_overlay

  task automatic t_boot();
    logic [31:0] q;
    do_reset(4'h2, 1'b0);
    host.send_byte(8'h00, 40);
    host.send_byte(8'h3C, 40);
    host.send_byte(8'hC3, 40);
    for (int i = 0; i < 50; i++) begin
      rd(REG_BOOT, q);
      if (q[11:0] === 12'h002) break;
    end
    chk("bytes loaded", 32'h2, {20'h0, q[11:0]});
    chk("bit period", 32'h1, {31'h0, q[31:12] >= 20'h27 && q[31:12] <= 20'h29});
    rd(REG_STATUS, q);
    chk("mode boot", {30'h0, OFP_BOOT}, {30'h0, q[SB_MODE+:2]});
    chk("rate locked", 32'h1, {31'h0, q[SB_LOCK]});
    wr(REG_ADDR, 32'h0);
    rd(REG_RAMDATA, q);
    chk("loaded bytes", 32'hC33C, {16'h0, q[15:0]});
  endtask : t_boot

  // ==========================================
  // main sequence
  initial begin
    clk_i       = 1'b0;
    rst_i       = 1'b1;
    wb_cyc_i    = 1'b0;
    wb_stb_i    = 1'b0;
    wb_we_i     = 1'b0;
    wb_adr_i    = 8'h00;
    wb_sel_i    = 4'hF;
    wb_dat_i    = 32'h0;
    mode_pins_i = 4'h0;
    hw_pin      = 1'b1;
    t_protect();
    t_erase();
    t_program();
    t_overlay();
    t_boot();
    complete_run();
  end
endmodule : testbench
